// *** hdl/dwbt_pkg.sv ***
package dwbt_pkg;
	// pin and latency widths
	localparam int          DQ_W        = 16;
	localparam int          LAT_W       = 5;
	// burst field of mode register 0
	localparam logic [1:0]  BF_BL8      = 2'h0;
	localparam logic [1:0]  BF_OTF      = 2'h1;
	localparam logic [1:0]  BF_BC4      = 2'h2;
	// additive latency select
	localparam logic [1:0]  AL_ZERO     = 2'h0;
	localparam logic [1:0]  AL_CLM1     = 2'h1;
	localparam logic [1:0]  AL_CLM2     = 2'h2;
	// index of the last beat per burst, and clocks a chop occupies on the link
	localparam logic [2:0]  BEATS_BL8   = 3'h7;
	localparam logic [2:0]  BEATS_BC4   = 3'h3;
	localparam logic [2:0]  BC4_CK      = 3'h2;
	// otf chop: reference edge this many link clocks after the first data edge
	localparam logic [2:0]  OTF_REF_CK  = 3'h4;
	localparam logic [2:0]  OTF_PAD_CK  = OTF_REF_CK - BC4_CK;
	// async power-down latency is write latency minus this
	localparam logic [4:0]  ANPD_SUB    = 5'h01;
	// reset values
	localparam logic [4:0]  LAT_RST     = 5'h00;
	localparam logic [DQ_W-1:0] DQ_RST  = 16'h0000;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic a12;
	} dwbt_cmd_s;

	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic [2:0]      beat;
		logic            last;
	} dwbt_beat_s;
endpackage

// *** hdl/dwbt_pin_sync.sv ***
`timescale 1ns/1ps
module dwbt_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	// raw pins
	input  wire logic [W-1:0] pin_i,
	// filtered level and edges
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else if (ce_i) begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			// a change counts only once the second and third stage agree
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					level_o[g] <= 1'b0;
					rise_o[g]  <= 1'b0;
					fall_o[g]  <= 1'b0;
				end else if (ce_i) begin
					rise_o[g] <= (s2[g] == s3[g]) && s3[g] && !level_o[g];
					fall_o[g] <= (s2[g] == s3[g]) && !s3[g] && level_o[g];
					if (s2[g] == s3[g]) begin
						level_o[g] <= s3[g];
					end
				end
			end
		end
	endgenerate
endmodule

// *** hdl/dwbt_write_path.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - write latency equals additive plus CAS write latency
// - AL=CL-1, CL=5, CWL=5 gives WL of 9
// - field 00, or 01 with A12 high: eight beats
// - field 10: every burst is chop of four
// - field 01 with A12 low: chop of four
// - otf length decided per command from sampled A12
// - async power-down latency is WL minus one
module dwbt_write_path (
	// clock, reset, enable
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       ce_i,
	// link pins
	input  wire logic                       ck_i,
	input  wire dwbt_pkg::dwbt_cmd_s        cmd_i,
	input  wire logic [dwbt_pkg::DQ_W-1:0]  dq_i,
	input  wire logic                       dqs_i,
	// configuration
	input  wire logic [1:0]                 burst_mode_i,
	input  wire logic [1:0]                 al_sel_i,
	input  wire logic [4:0]                 cl_i,
	input  wire logic [4:0]                 cwl_i,
	// status
	output logic      [4:0]                 wl_o,
	output logic      [4:0]                 anpd_o,
	output logic                            busy_o,
	output logic                            chop_o,
	output logic                            drop_o,
	output logic                            wr_ref_o,
	// captured data
	output dwbt_pkg::dwbt_beat_s            beat_o,
	output logic                            beat_valid_o
);
	localparam int SW = dwbt_pkg::DQ_W + 7;

	typedef enum logic [2:0] {
		S_IDLE,
		S_LAT,
		S_DATA,
		S_REF,
		S_PAD
	} dwbt_state_e;

	logic                      rst_q1;
	logic                      rst_n;
	logic [SW-1:0]             lvl;
	logic [SW-1:0]             rise;
	logic [SW-1:0]             fall;
	dwbt_pkg::dwbt_cmd_s       cmd_s;
	logic                      ck_rise;
	logic                      dqs_rise;
	logic                      dqs_fall;
	logic [4:0]                al_val;
	logic [4:0]                next_wl;
	logic                      wr_cmd;
	logic                      next_chop;
	logic                      next_otf;
	dwbt_state_e               state;
	logic [4:0]                lat_cnt;
	logic [2:0]                beat;
	logic [2:0]                pad_cnt;
	logic                      started;
	logic                      otf_chop;
	logic                      cap;

	// reset release through two flops
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// all pins share one filter so their delays match
	dwbt_pin_sync #(
		.W(SW)
	) u_sync (
		.clk_i  (clk_i),
		.rst_n_i(rst_n),
		.ce_i   (ce_i),
		.pin_i  ({ck_i, dqs_i, cmd_i, dq_i}),
		.level_o(lvl),
		.rise_o (rise),
		.fall_o (fall)
	);

	assign ck_rise  = rise[SW-1];
	assign dqs_rise = rise[SW-2];
	assign dqs_fall = fall[SW-2];
	assign cmd_s    = lvl[dwbt_pkg::DQ_W +: 5];

	always_comb begin
		if (al_sel_i == dwbt_pkg::AL_CLM1) begin
			al_val = cl_i - 5'h01;
		end else if (al_sel_i == dwbt_pkg::AL_CLM2) begin
			al_val = cl_i - 5'h02;
		end else begin
			al_val = dwbt_pkg::LAT_RST;
		end
		next_wl = al_val + cwl_i;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wl_o   <= dwbt_pkg::LAT_RST;
			anpd_o <= dwbt_pkg::LAT_RST;
		end else if (ce_i) begin
			wl_o   <= next_wl;
			anpd_o <= next_wl - dwbt_pkg::ANPD_SUB;
		end
	end

	// command sampled at the link clock rising edge
	assign wr_cmd = ck_rise && !cmd_s.cs_n && cmd_s.ras_n && !cmd_s.cas_n && !cmd_s.we_n;

	// length from field and A12 of this command
	always_comb begin
		next_otf  = (burst_mode_i == dwbt_pkg::BF_OTF) && !cmd_s.a12;
		next_chop = (burst_mode_i == dwbt_pkg::BF_BC4) || next_otf;
	end

	// beats on both strobe edges, counted from the first rise
	assign cap = (state == S_DATA) && (dqs_rise || (dqs_fall && started));

	// only one write in flight; a second one before the reference edge is dropped
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state    <= S_IDLE;
			lat_cnt  <= dwbt_pkg::LAT_RST;
			beat     <= 3'h0;
			pad_cnt  <= 3'h0;
			started  <= 1'b0;
			chop_o   <= 1'b0;
			otf_chop <= 1'b0;
			wr_ref_o <= 1'b0;
			drop_o   <= 1'b0;
		end else if (ce_i) begin
			wr_ref_o <= 1'b0;
			drop_o   <= wr_cmd && (state != S_IDLE);
			case (state)
				S_IDLE: begin
					if (wr_cmd) begin
						chop_o   <= next_chop;
						otf_chop <= next_otf;
						lat_cnt  <= dwbt_pkg::LAT_RST;
						state    <= S_LAT;
					end
				end
				S_LAT: begin
					// arm one clock early so the strobe preamble is seen
					if (ck_rise) begin
						lat_cnt <= lat_cnt + 5'h01;
						if (lat_cnt + 5'h01 >= wl_o - 5'h01) begin
							beat    <= 3'h0;
							started <= 1'b0;
							state   <= S_DATA;
						end
					end
				end
				S_DATA: begin
					if (dqs_rise) begin
						started <= 1'b1;
					end
					if (cap) begin
						beat <= beat + 3'h1;
						if (beat == (chop_o ? dwbt_pkg::BEATS_BC4 : dwbt_pkg::BEATS_BL8)) begin
							state <= S_REF;
						end
					end
				end
				S_REF: begin
					// reference at first rising edge after last beat; otf chop goes on to S_PAD instead
					if (ck_rise) begin
						if (otf_chop) begin
							pad_cnt <= 3'h0;
							state   <= S_PAD;
						end else begin
							wr_ref_o <= 1'b1;
							state    <= S_IDLE;
						end
					end
				end
				S_PAD: begin
					// otf chop waits out the unused half burst
					if (ck_rise) begin
						pad_cnt <= pad_cnt + 3'h1;
						if (pad_cnt + 3'h1 == dwbt_pkg::OTF_PAD_CK) begin
							wr_ref_o <= 1'b1;
							state    <= S_IDLE;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			beat_o       <= '0;
			beat_valid_o <= 1'b0;
			busy_o       <= 1'b0;
		end else if (ce_i) begin
			busy_o       <= (state != S_IDLE) || wr_cmd;
			beat_valid_o <= cap;
			if (cap) begin
				beat_o.data <= lvl[dwbt_pkg::DQ_W-1:0];
				beat_o.beat <= beat;
				beat_o.last <= beat == (chop_o ? dwbt_pkg::BEATS_BC4 : dwbt_pkg::BEATS_BL8);
			end
		end
	end

	property p_wl_sum;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		rst_n && ce_i && $stable(al_sel_i) && $stable(cl_i) && $stable(cwl_i) |=> wl_o == $past(next_wl);
	endproperty
	a_wl_sum: assert property (p_wl_sum) else $error("write latency not AL plus CWL");

	property p_wl_nine;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		rst_n && ce_i && al_sel_i == dwbt_pkg::AL_CLM1 && cl_i == 5'h05 && cwl_i == 5'h05 |=> wl_o == 5'h09;
	endproperty
	a_wl_nine: assert property (p_wl_nine) else $error("AL=CL-1 example not nine");

	property p_bl8;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		state == S_IDLE && wr_cmd && (burst_mode_i == dwbt_pkg::BF_BL8 ||
			(burst_mode_i == dwbt_pkg::BF_OTF && cmd_s.a12)) |=> !chop_o;
	endproperty
	a_bl8: assert property (p_bl8) else $error("eight-beat write chopped");

	property p_bc4_fixed;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		state == S_IDLE && wr_cmd && burst_mode_i == dwbt_pkg::BF_BC4 |=> chop_o && !otf_chop;
	endproperty
	a_bc4_fixed: assert property (p_bc4_fixed) else $error("fixed chop not applied");

	property p_bc4_otf;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		state == S_IDLE && wr_cmd && burst_mode_i == dwbt_pkg::BF_OTF && !cmd_s.a12 |=> chop_o && otf_chop;
	endproperty
	a_bc4_otf: assert property (p_bc4_otf) else $error("otf chop not applied");

	property p_len_held;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		state != S_IDLE && $past(state) != S_IDLE |-> $stable(chop_o);
	endproperty
	a_len_held: assert property (p_len_held) else $error("burst length changed mid write");

	property p_anpd;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		// both come out of reset as zero, so skip that value
		$stable(wl_o) && wl_o != dwbt_pkg::LAT_RST |-> anpd_o == wl_o - 5'h01;
	endproperty
	a_anpd: assert property (p_anpd) else $error("power-down latency not WL-1");

	property p_last_beat;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		beat_valid_o && beat_o.last |-> beat_o.beat == (chop_o ? 3'h3 : 3'h7) ##1 state == S_REF;
	endproperty
	a_last_beat: assert property (p_last_beat) else $error("burst ended at wrong beat");

	property p_otf_pad;
		@(posedge clk_i) disable iff (!rst_n || !ce_i)
		state == S_REF && ck_rise && otf_chop |=> !wr_ref_o ##[1:40] wr_ref_o;
	endproperty
	a_otf_pad: assert property (p_otf_pad) else $error("otf chop reference not delayed");
endmodule

// *** dv/dwbt_ctrl_model.sv ***
`timescale 1ns/1ps
module dwbt_ctrl_model (
	// link pins toward the device
	output logic                ck_o,
	output dwbt_pkg::dwbt_cmd_s cmd_o,
	output logic [15:0]         dq_o,
	output logic                dqs_o
);
	localparam dwbt_pkg::dwbt_cmd_s IDLE = 5'h1e;
	initial begin
		ck_o = 1'b0;
		cmd_o = IDLE;
		dq_o = 16'h0000;
		dqs_o = 1'b0;
		// phase offset keeps ck edges off the clk edges
		#37;
		forever #400 ck_o = ~ck_o;
	end
	task automatic do_write(input logic a12, input int wl, input int beats, input logic [127:0] d,
		output time t0);
		@(negedge ck_o);
		cmd_o <= '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0, we_n: 1'b0, a12: a12};
		@(posedge ck_o);
		t0 = $time;
		@(negedge ck_o);
		cmd_o <= IDLE;
		// first beat WL clocks after command
		repeat (wl - 1) @(posedge ck_o);
		// strobe on ck edges, both edges
		for (int k = 0; k < beats; k++) begin
			#200 dq_o <= d[k*16 +: 16];
			if (k % 2 == 0) @(posedge ck_o);
			else @(negedge ck_o);
			dqs_o <= ~dqs_o;
		end
		// released data lines show no stale value
		#200 dq_o <= ~dq_o;
	endtask
	// stray write two clocks after the write command
	task automatic send_write(input logic a12);
		repeat (3) @(negedge ck_o);
		cmd_o <= '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0, we_n: 1'b0, a12: a12};
		@(negedge ck_o);
		cmd_o <= IDLE;
	endtask
endmodule

// *** dv/test_ddr3_write_burst_timing.sv ***
`timescale 1ns/1ps
module test_ddr3_write_burst_timing;
	logic                 clk_i = 1'b0;
	logic                 resetn_i = 1'b0;
	logic                 ce_i = 1'b1;
	logic                 ck;
	dwbt_pkg::dwbt_cmd_s  cmd;
	logic [15:0]          dq;
	logic                 dqs;
	logic [1:0]           burst_mode_i = 2'h0;
	logic [1:0]           al_sel_i = 2'h0;
	logic [4:0]           cl_i = 5'h05;
	logic [4:0]           cwl_i = 5'h05;
	logic [4:0]           wl_o;
	logic [4:0]           anpd_o;
	logic                 busy_o;
	logic                 chop_o;
	logic                 drop_o;
	logic                 wr_ref_o;
	dwbt_pkg::dwbt_beat_s beat_o;
	logic                 beat_valid_o;
	dwbt_pkg::dwbt_beat_s got_q[$];
	time                  t_beat;
	time                  t_ref;
	int                   fails = 0;
	int                   num_checks = 0;
	int                   n_drop = 0;
	logic                 dup = 1'b0;
	logic [31:0]          rnd = 32'h1314c72b;

	always #50 clk_i = ~clk_i;

	dwbt_ctrl_model ctrl (.ck_o(ck), .cmd_o(cmd), .dq_o(dq), .dqs_o(dqs));
	dwbt_write_path uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .ck_i(ck), .cmd_i(cmd), .dq_i(dq),
		.dqs_i(dqs), .burst_mode_i(burst_mode_i), .al_sel_i(al_sel_i), .cl_i(cl_i), .cwl_i(cwl_i),
		.wl_o(wl_o), .anpd_o(anpd_o), .busy_o(busy_o), .chop_o(chop_o), .drop_o(drop_o),
		.wr_ref_o(wr_ref_o), .beat_o(beat_o), .beat_valid_o(beat_valid_o));

	// sampled mid-cycle so registered pulses have settled
	always @(negedge clk_i) begin
		if (beat_valid_o === 1'b1) begin
			got_q.push_back(beat_o);
			if (got_q.size() == 1) t_beat = $time;
		end
		if (wr_ref_o === 1'b1) t_ref = $time;
		if (drop_o === 1'b1) n_drop++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int exp_wl(input logic [1:0] als, input int cl, input int cwl);
		return (als == dwbt_pkg::AL_CLM1 ? cl - 1 : als == dwbt_pkg::AL_CLM2 ? cl - 2 : 0) + cwl;
	endfunction
	// clk edges from a pin edge to an output sampled mid-cycle
	function automatic int cyc(input time dt);
		return int'((dt + 49) / 100);
	endfunction

	task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_beat(input dwbt_pkg::dwbt_beat_s got, input dwbt_pkg::dwbt_beat_s exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic run_write(input logic [1:0] bm, input logic [1:0] als, input int cl, input int cwl,
		input logic a12);
		logic [127:0]         d;
		int                   wl;
		int                   beats;
		int                   refck;
		logic                 chop;
		time                  t0;
		dwbt_pkg::dwbt_beat_s e;
		@(posedge clk_i);
		burst_mode_i <= bm;
		al_sel_i <= als;
		cl_i <= 5'(cl);
		cwl_i <= 5'(cwl);
		repeat (3) @(posedge clk_i);
		wl = exp_wl(als, cl, cwl);
		chop = (bm == dwbt_pkg::BF_BC4) || (bm == dwbt_pkg::BF_OTF && !a12);
		beats = chop ? 4 : 8;
		refck = (bm == dwbt_pkg::BF_BC4) ? wl + 2 : wl + 4;
		chk_num({27'h0, wl_o}, 32'(wl));
		chk_num({27'h0, anpd_o}, 32'(wl - 1));
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			d[i*32 +: 32] = rnd;
		end
		got_q.delete();
		t_ref = 0;
		n_drop = 0;
		fork
			ctrl.do_write(a12, wl, beats, d, t0);
			if (dup) ctrl.send_write(~a12);
		join
		for (int i = 0; i < 400 && t_ref == 0; i++) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
		chk_num(32'(got_q.size()), 32'(beats));
		chk_num({31'h0, chop_o}, {31'h0, chop});
		chk_num(32'(n_drop), {31'h0, dup});
		for (int k = 0; k < beats && k < got_q.size(); k++) begin
			e = '{data: d[k*16 +: 16], beat: 3'(k), last: k == beats - 1};
			chk_beat(got_q[k], e);
		end
		chk_num(32'(cyc(t_beat - t0)), 32'(wl * 8 + 5));
		chk_num(32'(cyc(t_ref - t0)), 32'(refck * 8 + 5));
		chk_num({31'h0, busy_o}, 32'h0);
		// next command only after the reference edge
		@(posedge ck);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#1_000_000;
		fails++;
		wrap_up;
	end

	initial begin
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		run_write(dwbt_pkg::BF_BL8, dwbt_pkg::AL_ZERO, 5, 5, 1'b0);
		@(posedge clk_i);
		ce_i <= 1'b0;
		cwl_i <= 5'h06;
		repeat (3) @(posedge clk_i);
		chk_num({27'h0, wl_o}, 32'(exp_wl(dwbt_pkg::AL_ZERO, 5, 5)));
		ce_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_num({27'h0, wl_o}, 32'(exp_wl(dwbt_pkg::AL_ZERO, 5, 6)));
		run_write(dwbt_pkg::BF_OTF, dwbt_pkg::AL_CLM1, 5, 5, 1'b1);
		dup = 1'b1;
		run_write(dwbt_pkg::BF_OTF, dwbt_pkg::AL_ZERO, 5, 5, 1'b0);
		dup = 1'b0;
		run_write(dwbt_pkg::BF_BC4, dwbt_pkg::AL_CLM2, 6, 5, 1'b1);
		run_write(dwbt_pkg::BF_OTF, 2'h3, 7, 6, 1'b1);
		for (int n = 0; n < 8; n++) begin
			rnd = lfsr(rnd);
			dup = rnd[9];
			run_write(2'(rnd % 3), rnd[3:2], 5 + rnd[5:4], 5 + rnd[7:6], rnd[8]);
		end
		wrap_up;
	end
endmodule
